// ### inc/cvr_pkg.sv
// package for the buffer decrypt and tag value-read command block
package cvr_pkg;
	// command codes
	localparam logic [7:0] CMD_DECRYPT = 8'h09;
	localparam logic [7:0] CMD_VALUE_READ = 8'h0A;
	// register byte addresses on the plain register port
	localparam logic [8:0] REG_RESULT = 9'h000;
	localparam logic [8:0] REG_CMD = 9'h001;
	localparam logic [8:0] REG_ARG0 = 9'h002;
	localparam int ARG_COUNT = 9;
	localparam logic [8:0] REG_SEC = 9'h040;
	localparam int SEC_BYTES = 64;
	localparam logic [5:0] SEC_KEY0 = 6'h00;
	localparam logic [5:0] SEC_KEY1 = 6'h10;
	localparam logic [5:0] SEC_IV0 = 6'h20;
	localparam logic [5:0] SEC_IV1 = 6'h30;
	localparam int BUF_BIT = 8;
	// result codes and field positions
	localparam logic [1:0] RES_NONE = 2'h0;
	localparam logic [1:0] RES_OK = 2'h1;
	localparam logic [1:0] RES_FAIL = 2'h2;
	localparam logic [1:0] RES_BADCMD = 2'h3;
	localparam int RES_BUSY_BIT = 7;
	localparam logic [7:0] SEL_MAX = 8'h01;
	localparam int KSEL_ROLE_BIT = 7;
	localparam int KSEL_INLINE_BIT = 6;
	localparam logic [5:0] KEY_IDX_MAX = 6'h27;
	localparam int INLINE_KEY_BYTES = 6;
	localparam logic [8:0] VAL_BYTES = 9'h005;
	localparam logic [2:0] VAL_LAST = 3'h4;
	localparam int NBLK = 16;
	localparam int BLK_BYTES = 16;
	// cipher constants
	localparam logic [3:0] AES_LAST = 4'h9;
	localparam logic [7:0] RCON_FIRST = 8'h01;
	localparam logic [7:0] GF_POLY = 8'h1B;
	localparam logic [7:0] AFF_FWD = 8'h63;
	localparam logic [7:0] AFF_INV = 8'h05;
	localparam logic [7:0] GF_INV_EXP = 8'hFE;
	// register port request
	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cvr_bus_t;
	// request to the tag transceiver
	typedef struct packed {
		logic [7:0] block;
		logic role_b;
		logic [5:0] key_idx;
		logic inline_en;
		logic [47:0] inline_key;
	} cvr_tag_req_t;
	// answer from the tag transceiver, byte 0 in bits 127:120
	typedef struct packed {
		logic ok;
		logic [127:0] data;
	} cvr_tag_rsp_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DRD = 3'b001,
		ST_DGO = 3'b010,
		ST_DAES = 3'b011,
		ST_VREQ = 3'b100,
		ST_VWAIT = 3'b101,
		ST_VWR = 3'b110
	} cvr_state_t;
	typedef enum logic [1:0] {
		AS_IDLE = 2'b00,
		AS_EXP = 2'b01,
		AS_RND = 2'b10
	} cvr_aes_state_t;
endpackage

// ### hw/cvr_buf_mem.sv
// data buffer memory, word port plus registered byte read with bypass
module cvr_buf_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 128
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset, high
	input wire logic ce, // clock enable
	input wire logic [$clog2(DEPTH)-1:0] addr, // word address
	input wire logic we, // write strobe
	input wire logic [WIDTH/8-1:0] be, // byte lane enables
	input wire logic [WIDTH-1:0] wdata, // write word
	output logic [WIDTH-1:0] rdata_q, // registered read word
	input wire logic [$clog2(WIDTH/8)-1:0] bsel, // byte lane for byte read
	input wire logic alt_sel, // take alt_data instead of memory byte
	input wire logic [7:0] alt_data, // bypass byte
	output logic [7:0] rbyte_q // registered read byte
);
	logic [WIDTH-1:0] mem [DEPTH];

	// per-lane write
	for (genvar g = 0; g < WIDTH / 8; g++) begin : g_lane
		always_ff @(posedge clk) begin
			if (ce && we && be[g]) begin
				mem[addr][8*g +: 8] <= wdata[8*g +: 8];
			end
		end
	end

	// registered read outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
			rbyte_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= mem[addr];
			rbyte_q <= alt_sel ? alt_data : mem[addr][8*bsel +: 8];
		end
	end
endmodule // cvr_buf_mem

// ### hw/cvr_aes_dec.sv
// iterative 128-bit block inverse cipher, one round per cycle
module cvr_aes_dec (
	input wire logic clk, // clock
	input wire logic rst, // async reset, high
	input wire logic ce, // clock enable
	input wire logic start, // one-cycle start pulse
	input wire logic [127:0] key, // cipher key, byte 0 in msb
	input wire logic [127:0] ct, // cipher block
	output logic done_q, // one-cycle done pulse
	output logic [127:0] pt_q // inverse cipher output
);
	cvr_pkg::cvr_aes_state_t st_q, st_d;
	logic [127:0] rk_q, rk_d, s_q, s_d, ct_q, ct_d, pt_d, rnd, fwd, inv;
	logic [7:0] rc_q, rc_d;
	logic [3:0] cnt_q, cnt_d;
	logic done_d;
	logic [31:0] t, kw;

	function automatic logic [7:0] xt(input logic [7:0] b);
		return {b[6:0], 1'b0} ^ (b[7] ? cvr_pkg::GF_POLY : 8'h00);
	endfunction
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p, x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ x;
			x = xt(x);
		end
		return p;
	endfunction
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] r, y;
		r = 8'h01;
		y = a;
		for (int i = 0; i < 8; i++) begin
			if (cvr_pkg::GF_INV_EXP[i]) r = gmul(r, y);
			y = gmul(y, y);
		end
		return r;
	endfunction
	function automatic logic [7:0] sbox(input logic [7:0] a);
		logic [7:0] b;
		b = ginv(a);
		return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]}
			^ cvr_pkg::AFF_FWD;
	endfunction
	function automatic logic [7:0] isbox(input logic [7:0] b);
		return ginv({b[6:0], b[7]} ^ {b[4:0], b[7:5]} ^ {b[1:0], b[7:2]} ^ cvr_pkg::AFF_INV);
	endfunction

	// key schedule step, forward while expanding, backward while decrypting
	always_comb begin
		kw = (st_q == cvr_pkg::AS_EXP) ? rk_q[31:0] : (rk_q[31:0] ^ rk_q[63:32]);
		for (int i = 0; i < 4; i++) begin
			t[31-8*i -: 8] = sbox(kw[31-8*((i+1)%4) -: 8]); // rotate word left by one byte
		end
		t = t ^ {rc_q, 24'h000000};
		fwd[127:96] = rk_q[127:96] ^ t;
		fwd[95:64] = rk_q[95:64] ^ fwd[127:96];
		fwd[63:32] = rk_q[63:32] ^ fwd[95:64];
		fwd[31:0] = rk_q[31:0] ^ fwd[63:32];
		inv = {rk_q[127:96] ^ t, rk_q[95:64] ^ rk_q[127:96], rk_q[63:32] ^ rk_q[95:64],
			rk_q[31:0] ^ rk_q[63:32]};
	end

	// one inverse round: shift rows, substitute, add key, mix columns
	always_comb begin
		logic [7:0] b [16];
		for (int n = 0; n < 16; n++) b[n] = 8'h00;
		for (int n = 0; n < 16; n++) begin
			b[n] = isbox(s_q[127-8*(4*(((n/4)-(n%4)+4)%4)+(n%4)) -: 8]) ^ inv[127-8*n -: 8];
		end
		for (int n = 0; n < 16; n++) begin
			if (cnt_q == cvr_pkg::AES_LAST) begin
				rnd[127-8*n -: 8] = b[n];
			end else begin
				rnd[127-8*n -: 8] = gmul(b[n], 8'h0E) ^ gmul(b[4*(n/4)+(n+1)%4], 8'h0B)
					^ gmul(b[4*(n/4)+(n+2)%4], 8'h0D) ^ gmul(b[4*(n/4)+(n+3)%4], 8'h09);
			end
		end
	end

	// sequencing
	always_comb begin
		st_d = st_q;
		rk_d = rk_q;
		rc_d = rc_q;
		cnt_d = cnt_q;
		s_d = s_q;
		ct_d = ct_q;
		pt_d = pt_q;
		done_d = 1'b0;
		unique case (st_q)
			cvr_pkg::AS_IDLE: begin
				if (start) begin
					rk_d = key;
					ct_d = ct;
					rc_d = cvr_pkg::RCON_FIRST;
					cnt_d = 4'h0;
					st_d = cvr_pkg::AS_EXP;
				end
			end
			cvr_pkg::AS_EXP: begin
				rk_d = fwd;
				cnt_d = cnt_q + 4'h1;
				rc_d = xt(rc_q);
				if (cnt_q == cvr_pkg::AES_LAST) begin
					rc_d = rc_q; // last round constant walks back from here
					s_d = ct_q ^ fwd;
					cnt_d = 4'h0;
					st_d = cvr_pkg::AS_RND;
				end
			end
			cvr_pkg::AS_RND: begin
				s_d = rnd;
				rk_d = inv;
				rc_d = rc_q[0] ? {1'b1, rc_q[7:1] ^ cvr_pkg::GF_POLY[7:1]} : {1'b0, rc_q[7:1]};
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == cvr_pkg::AES_LAST) begin
					pt_d = rnd;
					done_d = 1'b1;
					st_d = cvr_pkg::AS_IDLE;
				end
			end
			default: st_d = cvr_pkg::AS_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= cvr_pkg::AS_IDLE;
			rk_q <= '0;
			rc_q <= 8'h00;
			cnt_q <= 4'h0;
			s_q <= '0;
			ct_q <= '0;
			pt_q <= '0;
			done_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			rk_q <= rk_d;
			rc_q <= rc_d;
			cnt_q <= cnt_d;
			s_q <= s_d;
			ct_q <= ct_d;
			pt_q <= pt_d;
			done_q <= done_d;
		end
	end
endmodule // cvr_aes_dec

// ### hw/cvr_cmd_exec.sv
// command executor for buffer decrypt and tag value read
// Functional notes
// - Command code 0x09 selects chained decryption of the data buffer.
// - Decrypt takes key number, vector number, block offset, block length.
// - Exactly the requested number of 16-byte blocks are decrypted, AES-128 CBC.
// - Decrypt reads and writes only the internal data buffer.
// - First block xors the vector; later blocks xor the previous ciphertext.
// - One selected key serves every block of a command.
// - Each ciphertext block is replaced by its plaintext in place.
// - Command code 0x0A selects the tag value read.
// - Selector: low six bits key 0..39, bit 7 second role, bit 6 inline.
// - Inline key used only with bit 6 set, least significant byte first.
// - Authentication and fetch are those of the ordinary block read.
// - A signed value and an address byte are decoded from the block.
// - After success the value goes to the offset, address byte right after.
// - Value stored as 32-bit two's complement lsb first, address as 8 bits.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module cvr_cmd_exec (
	input wire logic clk, // clock
	input wire logic rst, // async reset, high
	input wire logic ce, // clock enable
	input wire cvr_pkg::cvr_bus_t bus, // register port request
	output logic [7:0] rdata, // read data, cycle after read strobe
	output logic tag_req_valid_q, // one-cycle tag request pulse
	output cvr_pkg::cvr_tag_req_t tag_req_q, // tag request contents
	input wire logic tag_rsp_valid, // one-cycle tag answer pulse
	input wire cvr_pkg::cvr_tag_rsp_t tag_rsp // tag answer contents
);
	cvr_pkg::cvr_state_t st_q, st_d;
	logic [7:0] args_q [cvr_pkg::ARG_COUNT];
	logic [7:0] args_d [cvr_pkg::ARG_COUNT];
	logic [7:0] sec_q [cvr_pkg::SEC_BYTES];
	logic [7:0] sec_d [cvr_pkg::SEC_BYTES];
	logic [7:0] cmd_q, cmd_d;
	logic [1:0] res_q, res_d;
	logic [3:0] blk_q, blk_d;
	logic [4:0] cnt_q, cnt_d;
	logic [127:0] key_q, key_d, prev_q, prev_d, ct_q, ct_d, key_pick, iv_pick, blk_data;
	logic [7:0] vptr_q, vptr_d;
	logic [39:0] vw_q, vw_d;
	logic [2:0] wcnt_q, wcnt_d;
	logic treq_v_d;
	cvr_pkg::cvr_tag_req_t treq_d;
	logic busy, host_cmd, dec_ok, val_ok, fmt_ok;
	logic mem_we, aes_start, aes_done, alt_sel;
	logic [3:0] mem_addr;
	logic [15:0] mem_be;
	logic [127:0] mem_wdata, mem_rdata, aes_pt;
	logic [7:0] alt_data;
	logic [7:0] tb [16];

	assign busy = (st_q != cvr_pkg::ST_IDLE);
	assign host_cmd = bus.we && (bus.addr == cvr_pkg::REG_CMD) && !busy;

	// register file writes, refused for args and keys while a command runs
	always_comb begin
		args_d = args_q;
		sec_d = sec_q;
		if (bus.we && !busy) begin
			for (int i = 0; i < cvr_pkg::ARG_COUNT; i++) begin
				if (bus.addr == cvr_pkg::REG_ARG0 + 9'(i)) args_d[i] = bus.wdata;
			end
			if (bus.addr[8:6] == cvr_pkg::REG_SEC[8:6]) sec_d[bus.addr[5:0]] = bus.wdata;
		end
	end

	// selected key and vector, byte 0 in the msb
	always_comb begin
		for (int i = 0; i < cvr_pkg::BLK_BYTES; i++) begin
			key_pick[127-8*i -: 8] = sec_q[(args_q[0][0] ? cvr_pkg::SEC_KEY1 : cvr_pkg::SEC_KEY0)
				+ 6'(i)];
			iv_pick[127-8*i -: 8] = sec_q[(args_q[1][0] ? cvr_pkg::SEC_IV1 : cvr_pkg::SEC_IV0)
				+ 6'(i)];
		end
	end

	// argument checks for both commands
	always_comb begin
		dec_ok = (args_q[0] <= cvr_pkg::SEL_MAX) && (args_q[1] <= cvr_pkg::SEL_MAX)
			&& (args_q[3] != 8'h00)
			&& ({1'b0, args_q[2]} + {1'b0, args_q[3]} <= 9'(cvr_pkg::NBLK));
		val_ok = (args_q[2][5:0] <= cvr_pkg::KEY_IDX_MAX)
			&& ({1'b0, args_q[1]} + cvr_pkg::VAL_BYTES <= 9'(cvr_pkg::NBLK * cvr_pkg::BLK_BYTES));
	end

	// value block layout check: v, ~v, v, a, ~a, a, ~a
	always_comb begin
		for (int n = 0; n < 16; n++) tb[n] = tag_rsp.data[127-8*n -: 8];
		fmt_ok = (tb[12] == tb[14]) && (tb[13] == ~tb[12]) && (tb[15] == ~tb[12]);
		for (int n = 0; n < 4; n++) begin
			fmt_ok = fmt_ok && (tb[n+4] == ~tb[n]) && (tb[n+8] == tb[n]);
		end
	end

	// command sequencer and buffer port control
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		res_d = res_q;
		blk_d = blk_q;
		cnt_d = cnt_q;
		key_d = key_q;
		prev_d = prev_q;
		ct_d = ct_q;
		vptr_d = vptr_q;
		vw_d = vw_q;
		wcnt_d = wcnt_q;
		treq_d = tag_req_q;
		treq_v_d = 1'b0;
		aes_start = 1'b0;
		mem_we = 1'b0;
		mem_be = 16'h0000;
		mem_wdata = {16{bus.wdata}};
		mem_addr = bus.addr[7:4];
		blk_data = aes_pt ^ prev_q;
		unique case (st_q)
			cvr_pkg::ST_IDLE: begin
				if (bus.we && bus.addr[cvr_pkg::BUF_BIT]) begin
					mem_we = 1'b1;
					mem_be = 16'h0001 << (4'hF - bus.addr[3:0]);
				end
				if (host_cmd) begin
					cmd_d = bus.wdata;
					res_d = cvr_pkg::RES_NONE;
					if (bus.wdata == cvr_pkg::CMD_DECRYPT) begin
						if (dec_ok) begin
							blk_d = args_q[2][3:0];
							cnt_d = args_q[3][4:0];
							key_d = key_pick;
							prev_d = iv_pick;
							st_d = cvr_pkg::ST_DRD;
						end else begin
							res_d = cvr_pkg::RES_FAIL;
						end
					end else if (bus.wdata == cvr_pkg::CMD_VALUE_READ) begin
						if (val_ok) begin
							treq_d.block = args_q[0];
							vptr_d = args_q[1];
							treq_d.role_b = args_q[2][cvr_pkg::KSEL_ROLE_BIT];
							treq_d.key_idx = args_q[2][5:0];
							treq_d.inline_en = args_q[2][cvr_pkg::KSEL_INLINE_BIT];
							treq_d.inline_key = '0;
							for (int i = 0; i < cvr_pkg::INLINE_KEY_BYTES; i++) begin
								if (args_q[2][cvr_pkg::KSEL_INLINE_BIT]) begin
									treq_d.inline_key[8*i +: 8] = args_q[3+i];
								end
							end
							st_d = cvr_pkg::ST_VREQ;
						end else begin
							res_d = cvr_pkg::RES_FAIL;
						end
					end else begin
						res_d = cvr_pkg::RES_BADCMD;
					end
				end
			end
			cvr_pkg::ST_DRD: begin
				mem_addr = blk_q;
				st_d = cvr_pkg::ST_DGO;
			end
			cvr_pkg::ST_DGO: begin
				mem_addr = blk_q;
				aes_start = 1'b1;
				ct_d = mem_rdata;
				st_d = cvr_pkg::ST_DAES;
			end
			cvr_pkg::ST_DAES: begin
				mem_addr = blk_q;
				if (aes_done) begin
					mem_we = 1'b1;
					mem_be = 16'hFFFF;
					mem_wdata = blk_data;
					prev_d = ct_q;
					blk_d = blk_q + 4'h1;
					cnt_d = cnt_q - 5'h01;
					if (cnt_q == 5'h01) begin
						res_d = cvr_pkg::RES_OK;
						st_d = cvr_pkg::ST_IDLE;
					end else begin
						st_d = cvr_pkg::ST_DRD;
					end
				end
			end
			cvr_pkg::ST_VREQ: begin
				treq_v_d = 1'b1;
				st_d = cvr_pkg::ST_VWAIT;
			end
			cvr_pkg::ST_VWAIT: begin
				if (tag_rsp_valid) begin
					if (tag_rsp.ok && fmt_ok) begin
						vw_d = {tb[12], tb[3], tb[2], tb[1], tb[0]};
						wcnt_d = 3'h0;
						st_d = cvr_pkg::ST_VWR;
					end else begin
						res_d = cvr_pkg::RES_FAIL;
						st_d = cvr_pkg::ST_IDLE;
					end
				end
			end
			cvr_pkg::ST_VWR: begin
				mem_addr = vptr_q[7:4];
				mem_we = 1'b1;
				mem_be = 16'h0001 << (4'hF - vptr_q[3:0]);
				mem_wdata = {16{vw_q[7:0]}};
				vw_d = {8'h00, vw_q[39:8]};
				vptr_d = vptr_q + 8'h01;
				wcnt_d = wcnt_q + 3'h1;
				if (wcnt_q == cvr_pkg::VAL_LAST) begin
					res_d = cvr_pkg::RES_OK;
					st_d = cvr_pkg::ST_IDLE;
				end
			end
			default: st_d = cvr_pkg::ST_IDLE;
		endcase
	end

	// register read data, buffer bytes come from the memory itself, zero while a command runs
	always_comb begin
		alt_sel = !(bus.re && bus.addr[cvr_pkg::BUF_BIT] && !busy);
		alt_data = 8'h00;
		if (bus.re) begin
			if (bus.addr == cvr_pkg::REG_RESULT) begin
				alt_data = {busy, 5'h00, res_q};
			end else if (bus.addr == cvr_pkg::REG_CMD) begin
				alt_data = cmd_q;
			end else if (bus.addr[8:6] == cvr_pkg::REG_SEC[8:6]) begin
				alt_data = sec_q[bus.addr[5:0]];
			end
			for (int i = 0; i < cvr_pkg::ARG_COUNT; i++) begin
				if (bus.addr == cvr_pkg::REG_ARG0 + 9'(i)) alt_data = args_q[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < cvr_pkg::ARG_COUNT; i++) args_q[i] <= 8'h00;
			for (int i = 0; i < cvr_pkg::SEC_BYTES; i++) sec_q[i] <= 8'h00;
		end else if (ce) begin
			args_q <= args_d;
			sec_q <= sec_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= cvr_pkg::ST_IDLE;
			cmd_q <= 8'h00;
			res_q <= cvr_pkg::RES_NONE;
			blk_q <= 4'h0;
			cnt_q <= 5'h00;
			key_q <= '0;
			prev_q <= '0;
			ct_q <= '0;
			vptr_q <= 8'h00;
			vw_q <= '0;
			wcnt_q <= 3'h0;
			tag_req_q <= '0;
			tag_req_valid_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			res_q <= res_d;
			blk_q <= blk_d;
			cnt_q <= cnt_d;
			key_q <= key_d;
			prev_q <= prev_d;
			ct_q <= ct_d;
			vptr_q <= vptr_d;
			vw_q <= vw_d;
			wcnt_q <= wcnt_d;
			tag_req_q <= treq_d;
			tag_req_valid_q <= treq_v_d;
		end
	end

	// data buffer: 16 blocks of 16 bytes
	cvr_buf_mem #(.DEPTH(cvr_pkg::NBLK), .WIDTH(128)) u_buf (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.addr(mem_addr),
		.we(mem_we),
		.be(mem_be),
		.wdata(mem_wdata),
		.rdata_q(mem_rdata),
		.bsel(4'hF - bus.addr[3:0]),
		.alt_sel(alt_sel),
		.alt_data(alt_data),
		.rbyte_q(rdata)
	);

	// block inverse cipher, key held for the whole command
	cvr_aes_dec u_aes (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(aes_start),
		.key(key_q),
		.ct(mem_rdata),
		.done_q(aes_done),
		.pt_q(aes_pt)
	);
endmodule // cvr_cmd_exec

// ### bench/cvr_cmd_exec_props.sv
// port checker for the decrypt and value read command executor
module cvr_cmd_exec_chk (
	input wire logic clk, // clock
	input wire logic rst, // async reset, high
	input wire logic ce, // clock enable
	input wire cvr_pkg::cvr_bus_t bus, // register port request
	input wire logic [7:0] rdata, // read data
	input wire logic tag_req_valid_q, // tag request pulse
	input wire cvr_pkg::cvr_tag_req_t tag_req_q, // tag request contents
	input wire logic tag_rsp_valid, // tag answer pulse
	input wire cvr_pkg::cvr_tag_rsp_t tag_rsp // tag answer contents
);
	logic [7:0] arg_q [0:3];
	logic [7:0] arg_d [0:3];
	logic [7:0] cmd_q;
	logic [7:0] cmd_d;
	logic cmdw;
	// shadow copies of the first arguments and the last command written
	assign cmdw = ce && bus.we && bus.addr == cvr_pkg::REG_CMD;
	always_comb begin
		arg_d = arg_q;
		cmd_d = cmdw ? bus.wdata : cmd_q;
		for (int i = 0; i < 4; i++)
			if (ce && bus.we && bus.addr == cvr_pkg::REG_ARG0 + 9'(i)) arg_d[i] = bus.wdata;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arg_q <= '{default: 8'h00};
			cmd_q <= 8'h00;
		end else begin
			arg_q <= arg_d;
			cmd_q <= cmd_d;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_req_single_pulse: assert property (tag_req_valid_q |=> !tag_req_valid_q [*2])
		else $error("tag request longer than one cycle");
	chk_req_after_cmd: assert property (
		tag_req_valid_q |-> $past(cmdw && bus.wdata == cvr_pkg::CMD_VALUE_READ, 2))
		else $error("tag request without value read command two cycles before");
	chk_req_fields_match: assert property (tag_req_valid_q |->
		tag_req_q.block == arg_q[0] && tag_req_q.key_idx == arg_q[2][5:0])
		else $error("tag request block or key number differs from arguments");
	chk_sel_role_bits: assert property (tag_req_valid_q |->
		tag_req_q.role_b == arg_q[2][7] && tag_req_q.inline_en == arg_q[2][6])
		else $error("tag request role or inline flag differs from selector");
	chk_key_in_range: assert property (
		tag_req_valid_q |-> tag_req_q.key_idx <= cvr_pkg::KEY_IDX_MAX)
		else $error("tag request key number above limit");
	chk_bad_key_stopped: assert property (
		cmdw && bus.wdata == cvr_pkg::CMD_VALUE_READ && arg_q[2][5:0] > cvr_pkg::KEY_IDX_MAX
		|=> ##1 !tag_req_valid_q)
		else $error("tag request issued for key number above limit");
	chk_inline_lsb_first: assert property (
		tag_req_valid_q && tag_req_q.inline_en |-> tag_req_q.inline_key[7:0] == arg_q[3])
		else $error("inline key low byte is not the first key argument");
	chk_inline_unused: assert property (
		tag_req_valid_q && !tag_req_q.inline_en |-> tag_req_q.inline_key == 48'h0)
		else $error("inline key present without inline flag");
	chk_req_stands: assert property (tag_req_valid_q |=> $stable(tag_req_q) [*3])
		else $error("tag request contents changed while outstanding");
	chk_cmd_readback: assert property (
		ce && bus.re && bus.addr == cvr_pkg::REG_CMD |=> rdata == cmd_q)
		else $error("command register read differs from last command");
	// main scenarios reached
	cov_decrypt: cover property (cmdw && bus.wdata == cvr_pkg::CMD_DECRYPT);
	cov_inline: cover property (tag_req_valid_q && tag_req_q.inline_en);
	cov_tag_fail: cover property (tag_rsp_valid && !tag_rsp.ok);
endmodule // cvr_cmd_exec_chk

// ### bench/cvr_tag_model.sv
// tag transceiver model: one answer for each block request after a set delay
module cvr_tag_model (
	input wire logic clk, // clock
	input wire logic rst, // async reset, high
	input wire logic req_valid, // request pulse
	input wire logic [7:0] delay, // extra answer delay in cycles
	input wire logic ok, // authentication and read outcome
	input wire logic [127:0] data, // block contents, byte 0 in msb
	output logic rsp_valid, // answer pulse
	output cvr_pkg::cvr_tag_rsp_t rsp // answer contents
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// answer counts down; contents flip every cycle outside the pulse
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			rsp_valid <= 1'b0;
			rsp <= '0;
		end else begin
			rsp_valid <= 1'b0;
			rsp <= ~rsp;
			if (req_valid) begin
				cnt <= int'(delay) + 1;
			end else if (cnt == 1) begin
				rsp_valid <= 1'b1;
				rsp <= {ok, data};
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule // cvr_tag_model

// ### bench/cvr_cmd_exec_tb.sv
// self-checking bench for the decrypt and value read command executor
module cvr_cmd_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
	localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
	localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [127:0] IV1 = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
	localparam logic [127:0] S = {16{8'h3C}};
	logic clk;
	logic rst;
	cvr_pkg::cvr_bus_t bus;
	logic [7:0] rdata;
	logic req_v;
	logic rsp_v;
	cvr_pkg::cvr_tag_req_t req;
	cvr_pkg::cvr_tag_rsp_t rsp;
	logic [7:0] dly;
	logic ok;
	logic [127:0] tdata;
	logic [7:0] r;
	logic [127:0] b;
	logic [31:0] bad [0:3];
	logic [23:0] badv [0:1];
	int err_count;
	int num_checks;
	cvr_cmd_exec uut (.clk(clk), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
		.tag_req_valid_q(req_v), .tag_req_q(req), .tag_rsp_valid(rsp_v), .tag_rsp(rsp));
	cvr_tag_model tag (.clk(clk), .rst(rst), .req_valid(req_v), .delay(dly), .ok(ok),
		.data(tdata), .rsp_valid(rsp_v), .rsp(rsp));
	// clock of 100 ns
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(string nm, logic [127:0] seen, logic [127:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [8:0] a, logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(logic [8:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		d = rdata;
	endtask
	task automatic wblk(logic [8:0] a, logic [127:0] d);
		for (int i = 0; i < 16; i++) wr(a + 9'(i), d[127-8*i -: 8]);
	endtask
	task automatic rblk(logic [8:0] a, output logic [127:0] d);
		logic [7:0] x;
		for (int i = 0; i < 16; i++) begin
			rd(a + 9'(i), x);
			d[127-8*i -: 8] = x;
		end
	endtask
	// write all arguments, start the command and poll until not busy
	task automatic run(logic [7:0] c, logic [71:0] a, output logic [7:0] res);
		for (int i = 0; i < 9; i++) wr(cvr_pkg::REG_ARG0 + 9'(i), a[71-8*i -: 8]);
		wr(cvr_pkg::REG_CMD, c);
		res = 8'h80;
		for (int n = 0; n < 400 && res[7] !== 1'b0; n++) rd(cvr_pkg::REG_RESULT, res);
	endtask
	function automatic logic [127:0] vblk(logic [31:0] v, logic [7:0] a);
		logic [31:0] s;
		s = {v[7:0], v[15:8], v[23:16], v[31:24]};
		return {s, ~s, s, a, ~a, a, ~a};
	endfunction
	task automatic conclude;
		if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, far beyond the thousand or so cycles the tests need
	initial begin
		#3000000;
		err_count++;
		conclude();
	end
	// test sequence
	initial begin
		bus = '0;
		rst = 1'b1;
		dly = 8'h05;
		ok = 1'b1;
		tdata = '0;
		err_count = 0;
		num_checks = 0;
		bad = '{32'h02000001, 32'h00020001, 32'h00000000, 32'h00000F02};
		badv = '{24'h045028, 24'h04FC05};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(cvr_pkg::REG_RESULT, r);
		chk("result after reset", r, 8'h00);
		wblk(9'h040, KEY);
		wblk(9'h050, ~KEY);
		wblk(9'h060, 128'h0);
		wblk(9'h070, IV1);
		wblk(9'h100, CT);
		wblk(9'h120, CT);
		wblk(9'h130, CT);
		wblk(9'h140, S);
		wblk(9'h1F0, CT);
		run(cvr_pkg::CMD_DECRYPT, {32'h00010202, 40'h0}, r);
		chk("decrypt result", r, 8'h01);
		rblk(9'h120, b);
		chk("first block", b, PT ^ IV1);
		rblk(9'h130, b);
		chk("second block", b, PT ^ CT);
		rblk(9'h140, b);
		chk("block after run", b, S);
		run(cvr_pkg::CMD_DECRYPT, {32'h00000F01, 40'h0}, r);
		chk("last block result", r, 8'h01);
		rblk(9'h1F0, b);
		chk("last block", b, PT);
		for (int k = 0; k < 4; k++) begin
			run(cvr_pkg::CMD_DECRYPT, {bad[k], 40'h0}, r);
			chk("bad decrypt result", r, 8'h02);
		end
		rblk(9'h100, b);
		chk("block zero kept", b, CT);
		rblk(9'h1F0, b);
		chk("block fifteen kept", b, PT);
		run(8'h07, 72'h0, r);
		chk("unknown command", r, 8'h03);
		rd(cvr_pkg::REG_CMD, r);
		chk("command readback", r, 8'h07);
		wblk(9'h150, S);
		tdata = vblk(32'hFFFFFF85, 8'h11);
		run(cvr_pkg::CMD_VALUE_READ, {24'h045085, 48'h0}, r);
		chk("value read result", r, 8'h01);
		chk("tag block", req.block, 8'h04);
		chk("tag role and key", {req.role_b, req.key_idx}, 7'h45);
		rblk(9'h150, b);
		chk("stored value", b, {40'h85FFFFFF11, S[87:0]});
		wblk(9'h150, S);
		ok = 1'b0;
		dly = 8'h00;
		run(cvr_pkg::CMD_VALUE_READ, {24'h045067, 48'h010203040506}, r);
		chk("failed read result", r, 8'h02);
		chk("inline key", req.inline_key, 48'h060504030201);
		ok = 1'b1;
		tdata = vblk(32'h00001234, 8'h22) ^ (128'h1 << 88);
		run(cvr_pkg::CMD_VALUE_READ, {24'h045005, 48'h0}, r);
		chk("bad format result", r, 8'h02);
		for (int k = 0; k < 2; k++) begin
			run(cvr_pkg::CMD_VALUE_READ, {badv[k], 48'h0}, r);
			chk("refused read result", r, 8'h02);
		end
		rblk(9'h150, b);
		chk("buffer kept", b, S);
		conclude();
	end
endmodule // cvr_cmd_exec_tb
bind cvr_cmd_exec cvr_cmd_exec_chk chk_i (.clk(clk), .rst(rst), .ce(ce), .bus(bus),
	.rdata(rdata), .tag_req_valid_q(tag_req_valid_q), .tag_req_q(tag_req_q),
	.tag_rsp_valid(tag_rsp_valid), .tag_rsp(tag_rsp));
